// ===== test/tb.sv
// Self-checking bench of the error and threshold block
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
    import aet_pkg::*;

    // ==============================================================
    // Signals
    logic              sys_clk;
    logic              rst_n;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              conv_start;
    logic              conv_active;
    logic              conv_done;
    logic [15:0]       latest_sample;
    logic [15:0]       first_sample;
    logic [15:0]       filtered_value;
    logic              threshold_irq;
    int                miscompares;
    int                checks;
    logic              armed;
    logic [15:0]       last_l;
    logic [31:0]       rd;
    int                vals [5] = '{-11, -10, 0, 10, 11};

    aet_core #(.DW(16)) u_aet_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_start(conv_start), .conv_active(conv_active), .conv_done(conv_done),
        .latest_sample(latest_sample), .first_sample(first_sample),
        .filtered_value(filtered_value), .threshold_irq(threshold_irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==============================================================
    // Closing report
    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==============================================================
    // Avalon-MM master: hold request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            finish_test();
        end
        // Taken at the edge where waitrequest is seen low, released right after it
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    // ==============================================================
    // One conversion; a pending retrigger start is used instead of a write
    task automatic conv(input logic [3:0] cfg, input logic [15:0] l, fs, fv,
                        input logic exp_irq, exp_rs);
        int   n;
        logic got;
        n   = 0;
        got = 1'b0;
        if (cfg != 4'h0) bus(1'b1, OFS_CONV, {28'h000_0000, cfg});
        while (!armed && conv_start !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        @(posedge sys_clk);
        conv_done      <= 1'b1;
        latest_sample  <= l;
        first_sample   <= fs;
        filtered_value <= fv;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        armed = 1'b0;
        repeat (4) begin
            @(negedge sys_clk);
            if (threshold_irq === 1'b1) got = 1'b1;
            if (conv_start === 1'b1) armed = 1'b1;
        end
        last_l = l;
        `CHK(got, exp_irq)
        `CHK(armed, exp_rs)
    endtask

    // Expected interrupt decision
    function automatic logic hit(input logic [2:0] m, input logic signed [17:0] e);
        case (m)
            3'h0: hit = 1'b0;
            3'h1: hit = e < -10;
            3'h2: hit = e >= -10;
            3'h3: hit = e > -10 && e < 10;
            3'h4: hit = e < -10 || e > 10;
            3'h5: hit = e <= 10;
            3'h6: hit = e > 10;
            default: hit = 1'b1;
        endcase
    endfunction

    // Expected error value
    function automatic logic signed [17:0] deviation_formula_select(input logic [2:0] c, input logic ds,
        input logic signed [17:0] r, p, f, s);
        logic signed [17:0] b;
        b = ds ? r - p : r;
        case (c)
            3'h0: deviation_formula_select = r - p;
            3'h1: deviation_formula_select = b - s;
            3'h2: deviation_formula_select = b - f;
            3'h4: deviation_formula_select = p - f;
            3'h5: deviation_formula_select = f - s;
            default: deviation_formula_select = 18'h0_0000;
        endcase
    endfunction

    // ==============================================================
    // Main sequence
    initial begin
        logic signed [17:0] e;
        logic signed [15:0] lv;
        logic signed [15:0] pv;
        rst_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = '0; conv_done = 1'b0; latest_sample = '0;
        first_sample = '0; filtered_value = '0; miscompares = 0; checks = 0;
        armed = 1'b0; last_l = '0; rd = '0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset value and unimplemented top bit
        bus(1'b0, OFS_CTRL3, 32'h0000_0000);
        `CHK(rd[7:0], 8'h00)
        `CHK(conv_active, 1'b0)
        bus(1'b1, OFS_CTRL3, 32'h0000_00FF);
        bus(1'b0, OFS_CTRL3, 32'h0000_0000);
        `CHK(rd[7:0], 8'h7F)
        // Every threshold mode at and around both limits
        bus(1'b1, OFS_SETPT, 32'h0000_0000);
        bus(1'b1, OFS_LOWER, 32'h0000_FFF6);
        bus(1'b1, OFS_UPPER, 32'h0000_000A);
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, OFS_CTRL3, {24'h00_0000, 4'h1, 1'b0, 3'(m)});
            for (int i = 0; i < 5; i++) begin
                e = 18'(vals[i]);
                conv(4'h9, 16'(vals[i]), 16'h0000, 16'h0000, hit(3'(m), e), 1'b0);
                bus(1'b0, OFS_ERROR, 32'h0000_0000);
                `CHK(rd[17:0], e)
            end
        end
        `CHK(conv_active, 1'b0)
        // Every formula code in single and double sampling
        bus(1'b1, OFS_SETPT, 32'h0000_001E);
        for (int ds = 0; ds < 2; ds++) begin
            for (int c = 0; c < 8; c++) begin
                lv = 16'(100 + c * 7 - ds * 300);
                pv = ds ? 16'h0019 : last_l;
                bus(1'b1, OFS_CTRL3, {24'h00_0000, 1'b0, 3'(c), 4'h7});
                conv(ds ? 4'h5 : 4'h9, lv, 16'h0019, 16'hFFD8, 1'b1, 1'b0);
                bus(1'b0, OFS_ERROR, 32'h0000_0000);
                e = deviation_formula_select(3'(c), 1'(ds), lv, pv, -18'sd40, 18'sd30);
                `CHK(rd[17:0], e)
            end
        end
        // Repeat with stop set: retrigger on a miss, halt on a hit
        bus(1'b1, OFS_SETPT, 32'h0000_0000);
        bus(1'b1, OFS_CTRL3, 32'h0000_001E);
        conv(4'hB, 16'h0005, 16'h0000, 16'h0000, 1'b0, 1'b1);
        `CHK(conv_active, 1'b1)
        conv(4'h0, 16'h0014, 16'h0000, 16'h0000, 1'b1, 1'b0);
        `CHK(conv_active, 1'b0)
        bus(1'b0, OFS_CTRL3, 32'h0000_0000);
        `CHK(rd[7:0], 8'h16)
        // Repeat with stop clear: only software ends it
        conv(4'hB, 16'h0014, 16'h0000, 16'h0000, 1'b1, 1'b1);
        `CHK(conv_active, 1'b1)
        bus(1'b1, OFS_CONV, 32'h0000_0000);
        armed = 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK(conv_active, 1'b0)
        finish_test();
    end
endmodule // tb

`default_nettype wire

// ===== verilog/aet_core.sv
// Error computation, threshold test and retrigger control with Avalon-MM registers
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module aet_core
    import aet_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Converter side
    output logic                   conv_start,
    output logic                   conv_active,
    input  wire logic              conv_done,
    input  wire logic [DW-1:0]     latest_sample,
    input  wire logic [DW-1:0]     first_sample,
    input  wire logic [DW-1:0]     filtered_value,
    // Threshold event
    output logic                   threshold_irq
);
    localparam int EW = DW + 2;

    // ==============================================================
    // Bus handshake: one wait cycle per access
    logic ack_q;
    logic wr_en;
    logic [31:0] rdata_d;
    logic [31:0] readdata_q;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_en           = avs_write & ack_q;
    assign avs_readdata    = readdata_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // ==============================================================
    // Registers
    logic [CTRL3_W-1:0] ctrl3_q;
    logic               go_q;
    logic               rep_q;
    logic               double_sample_enable_q;
    logic               prior_source_select_q;
    logic [DW-1:0]      setp_q;
    logic [DW-1:0]      lower_q;
    logic [DW-1:0]      upper_q;
    logic [EW-1:0]      err_q;
    logic [DW-1:0]      prev_q;
    logic               hit_q;
    aet_state_e         state_q;
    logic               hit;
    logic               stop_now;
    logic               retrig;
    logic               wr_ctrl3;
    logic               wr_conv;

    assign wr_ctrl3 = wr_en && (avs_address == OFS_CTRL3);
    assign wr_conv  = wr_en && (avs_address == OFS_CONV);

    wire [2:0] form_sel = ctrl3_q[FORM_LSB+:3];
    wire       stop_on_threshold = ctrl3_q[STOP_BIT];
    wire [2:0] mode_sel = ctrl3_q[MODE_LSB+:3];

    // Hardware clears the stop bit whenever repeat, stop and a hit coincide, in any state; a software write wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl3_q <= CTRL3_RESET;
        end else if (wr_ctrl3) begin
            ctrl3_q <= avs_writedata[CTRL3_W-1:0] & CTRL3_WMASK;
        end else if (stop_now) begin
            ctrl3_q[STOP_BIT] <= 1'b0;
        end
    end

    // Software set beats a same-cycle hardware clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_q   <= 1'b0;
            rep_q  <= 1'b0;
            double_sample_enable_q <= 1'b0;
            prior_source_select_q <= 1'b0;
        end else if (wr_conv) begin
            go_q   <= avs_writedata[CONV_GO_BIT];
            rep_q  <= avs_writedata[CONV_REP_BIT];
            double_sample_enable_q <= avs_writedata[CONV_DOUBLE_SAMPLE_ENABLE_BIT];
            prior_source_select_q <= avs_writedata[CONV_PRIOR_SOURCE_SELECT_BIT];
        end else if (state_q == AET_EVAL && !retrig) begin
            go_q   <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setp_q  <= '0;
            lower_q <= '0;
            upper_q <= '0;
        end else if (wr_en) begin
            if (avs_address == OFS_SETPT) begin
                setp_q <= avs_writedata[DW-1:0];
            end
            if (avs_address == OFS_LOWER) begin
                lower_q <= avs_writedata[DW-1:0];
            end
            if (avs_address == OFS_UPPER) begin
                upper_q <= avs_writedata[DW-1:0];
            end
        end
    end

    // ==============================================================
    // Error computation
    logic signed [EW-1:0] s_latest;
    logic signed [EW-1:0] s_prior;
    logic signed [EW-1:0] s_filt;
    logic signed [EW-1:0] s_setp;
    logic signed [EW-1:0] s_delta;
    logic signed [EW-1:0] s_base;
    logic signed [EW-1:0] err_d;

    always_comb begin
        s_latest = EW'(signed'(latest_sample));
        s_filt   = EW'(signed'(filtered_value));
        s_setp   = EW'(signed'(setp_q));
        // Prior is first sample or last stored result
        s_prior  = prior_source_select_q ? EW'(signed'(prev_q)) : EW'(signed'(first_sample));
        s_delta  = s_latest - s_prior;
        s_base   = double_sample_enable_q ? s_delta : s_latest;
        unique case (form_sel)
            FORM_FILT_SETP: err_d = s_filt - s_setp;
            FORM_PREV_FILT: err_d = s_prior - s_filt;
            FORM_BASE_FILT: err_d = s_base - s_filt;
            FORM_BASE_SETP: err_d = s_base - s_setp;
            FORM_DELTA:     err_d = s_delta;
            default:        err_d = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q  <= '0;
            prev_q <= '0;
        end else if (state_q == AET_WAIT && conv_done) begin
            err_q  <= err_d;
            prev_q <= latest_sample;
        end
    end

    // ==============================================================
    // Threshold test, limits sign-extended to the error width
    logic signed [EW-1:0] s_err;
    logic signed [EW-1:0] s_lo;
    logic signed [EW-1:0] s_hi;

    always_comb begin
        s_err = signed'(err_q);
        s_lo  = EW'(signed'(lower_q));
        s_hi  = EW'(signed'(upper_q));
        unique case (mode_sel)
            TMODE_ALWAYS:  hit = 1'b1;
            TMODE_GT_HI:   hit = s_err > s_hi;
            TMODE_LE_HI:   hit = s_err <= s_hi;
            TMODE_OUTSIDE: hit = s_err < s_lo || s_err > s_hi;
            TMODE_INSIDE:  hit = s_err > s_lo && s_err < s_hi;
            TMODE_GE_LO:   hit = s_err >= s_lo;
            TMODE_LT_LO:   hit = s_err < s_lo;
            TMODE_NEVER:   hit = 1'b0;
        endcase
    end

    // Without stop set only software ends a repeating run
    assign stop_now = rep_q && stop_on_threshold && hit;
    assign retrig   = go_q && rep_q && !stop_now && !wr_conv;

    // ==============================================================
    // Sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AET_IDLE;
        end else begin
            unique case (state_q)
                AET_IDLE: if (go_q && !wr_conv) begin
                    state_q <= AET_WAIT;
                end
                AET_WAIT: if (!go_q) begin
                    state_q <= AET_IDLE;
                end else if (conv_done) begin
                    state_q <= AET_EVAL;
                end
                AET_EVAL: state_q <= retrig ? AET_WAIT : AET_IDLE;
            endcase
        end
    end

    // Start pulse coincides with entry to the wait state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start    <= 1'b0;
            threshold_irq <= 1'b0;
            hit_q         <= 1'b0;
        end else begin
            conv_start <= (state_q == AET_IDLE && go_q && !wr_conv)
                       || (state_q == AET_EVAL && retrig);
            threshold_irq <= (state_q == AET_EVAL) && hit;
            if (state_q == AET_EVAL) begin
                hit_q <= hit;
            end
        end
    end

    assign conv_active = go_q;

    // ==============================================================
    // Read mux, unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            OFS_CTRL3:  rdata_d[CTRL3_W-1:0] = ctrl3_q;
            OFS_CONV:   rdata_d[3:0] = {prior_source_select_q, double_sample_enable_q, rep_q, go_q};
            OFS_SETPT:  rdata_d[DW-1:0] = setp_q;
            OFS_LOWER:  rdata_d[DW-1:0] = lower_q;
            OFS_UPPER:  rdata_d[DW-1:0] = upper_q;
            OFS_ERROR:  rdata_d = 32'(signed'(err_q));
            OFS_STATUS: rdata_d[2:0] = {hit_q, state_q == AET_EVAL, state_q == AET_WAIT};
            OFS_PRIOR:  rdata_d[DW-1:0] = prev_q;
            default:    rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            readdata_q <= rdata_d;
        end
    end

    // ==============================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_bit7_zero: assert property (ctrl3_q[7] == 1'b0)
        else $error("control bit 7 not zero");
    a_never_irq: assert property ((state_q == AET_EVAL && mode_sel == TMODE_NEVER)
        |=> !threshold_irq)
        else $error("interrupt raised in never mode");
    a_always_irq: assert property ((state_q == AET_EVAL && mode_sel == TMODE_ALWAYS)
        |=> threshold_irq)
        else $error("interrupt missing in always mode");
    a_irq_only_eval: assert property (threshold_irq |-> $past(state_q) == AET_EVAL)
        else $error("interrupt outside evaluation");
    a_gt_upper: assert property ((state_q == AET_EVAL && mode_sel == TMODE_GT_HI)
        |=> threshold_irq == ($signed($past(err_q)) > $signed(EW'(signed'($past(upper_q))))))
        else $error("upper test wrong");
    a_stop_clears: assert property ((state_q == AET_EVAL && rep_q && stop_on_threshold
        && hit && !wr_conv) |=> !conv_active && !conv_start)
        else $error("run not stopped on threshold");
    a_retrig: assert property ((state_q == AET_EVAL && go_q && rep_q && !hit && !wr_conv)
        |=> conv_start && state_q == AET_WAIT)
        else $error("no retrigger on miss");
    a_nostop_soft: assert property ((state_q == AET_EVAL && rep_q && !stop_on_threshold
        && go_q && !wr_conv) |=> conv_active)
        else $error("hardware cleared active without stop");
    a_reserved_zero: assert property ((state_q == AET_WAIT && conv_done && go_q
        && form_sel inside {3'h3, 3'h6, 3'h7}) |=> err_q == '0)
        else $error("reserved formula nonzero");
    a_wait_one: assert property ((avs_read || avs_write) && !ack_q |=> !avs_waitrequest)
        else $error("bus answer late");
    a_idle_nowait: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without a request");

    // ==============================================================
    // Threshold mode checks, one per comparison except greater-than-upper, which is checked above
    a_lt_lower: assert property (
        (state_q == AET_EVAL && mode_sel == TMODE_LT_LO)
        |=> threshold_irq == ($past(s_err) < $past(s_lo)))
        else $error("below-lower test wrong");
    a_ge_lower: assert property (
        (state_q == AET_EVAL && mode_sel == TMODE_GE_LO)
        |=> threshold_irq == ($past(s_err) >= $past(s_lo)))
        else $error("at-or-above-lower test wrong");
    a_inside_band: assert property (
        (state_q == AET_EVAL && mode_sel == TMODE_INSIDE)
        |=> threshold_irq == ($past(s_err) > $past(s_lo) && $past(s_err) < $past(s_hi)))
        else $error("inside-band test wrong");
    a_outside_band: assert property (
        (state_q == AET_EVAL && mode_sel == TMODE_OUTSIDE)
        |=> threshold_irq == ($past(s_err) < $past(s_lo) || $past(s_err) > $past(s_hi)))
        else $error("outside-band test wrong");
    a_le_upper: assert property (
        (state_q == AET_EVAL && mode_sel == TMODE_LE_HI)
        |=> threshold_irq == ($past(s_err) <= $past(s_hi)))
        else $error("at-or-below-upper test wrong");

    // ==============================================================
    // Sequencing and pulse checks
    a_stop_bit_hw: assert property (
        (state_q == AET_EVAL && stop_now && !wr_ctrl3)
        |=> !stop_on_threshold)
        else $error("stop bit not cleared on threshold stop");
    a_single_go: assert property (
        (state_q == AET_EVAL && !rep_q && !wr_conv)
        |=> !conv_active)
        else $error("single conversion left active");
    a_start_pulse: assert property (
        conv_start
        |=> !conv_start)
        else $error("start pulse longer than one cycle");
    a_irq_pulse: assert property (
        threshold_irq
        |=> !threshold_irq)
        else $error("interrupt pulse longer than one cycle");
    a_no_idle_start: assert property (
        (state_q == AET_IDLE && !go_q)
        |=> !conv_start)
        else $error("start without conversion active");
    a_err_hold: assert property (
        !(state_q == AET_WAIT && conv_done)
        |=> $stable(err_q))
        else $error("error changed outside a computation");
    a_prior_store: assert property (
        (state_q == AET_WAIT && conv_done)
        |=> prev_q == $past(latest_sample))
        else $error("prior result not stored");
    a_done_ignored: assert property (
        (state_q == AET_IDLE && conv_done)
        |=> state_q != AET_EVAL)
        else $error("completion taken outside wait");

    c_stop_run: cover property (state_q == AET_EVAL && stop_now);
    c_retrig:   cover property (state_q == AET_EVAL && retrig);
    c_irq:      cover property (threshold_irq && mode_sel == TMODE_OUTSIDE);
    c_double:   cover property (conv_done && double_sample_enable_q && state_q == AET_WAIT);
    c_reserved: cover property (conv_done && state_q == AET_WAIT && form_sel == 3'h3);
endmodule // aet_core

`default_nettype wire

// ===== verilog/aet_pkg.sv
// Package: register map, field layout and codes of the error/threshold block
package aet_pkg;
    // ==============================================================
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL3  = 5'h00;
    localparam logic [4:0] OFS_CONV   = 5'h04;
    localparam logic [4:0] OFS_SETPT  = 5'h08;
    localparam logic [4:0] OFS_LOWER  = 5'h0C;
    localparam logic [4:0] OFS_UPPER  = 5'h10;
    localparam logic [4:0] OFS_ERROR  = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam logic [4:0] OFS_PRIOR  = 5'h1C;
    localparam int         ADDR_W     = 5;

    // ==============================================================
    // Control register three fields
    localparam int         CTRL3_W     = 8;
    localparam logic [7:0] CTRL3_RESET = 8'h00;
    localparam int         FORM_LSB    = 4;
    localparam int         STOP_BIT    = 3;
    localparam int         MODE_LSB    = 0;
    localparam logic [7:0] CTRL3_WMASK = 8'h7F;

    // ==============================================================
    // Conversion control fields
    localparam int CONV_GO_BIT   = 0;
    localparam int CONV_REP_BIT  = 1;
    localparam int CONV_DOUBLE_SAMPLE_ENABLE_BIT = 2;
    localparam int CONV_PRIOR_SOURCE_SELECT_BIT = 3;

    // ==============================================================
    // Formula codes
    localparam logic [2:0] FORM_DELTA     = 3'h0;
    localparam logic [2:0] FORM_BASE_SETP = 3'h1;
    localparam logic [2:0] FORM_BASE_FILT = 3'h2;
    localparam logic [2:0] FORM_PREV_FILT = 3'h4;
    localparam logic [2:0] FORM_FILT_SETP = 3'h5;

    // ==============================================================
    // Threshold modes
    localparam logic [2:0] TMODE_NEVER   = 3'h0;
    localparam logic [2:0] TMODE_LT_LO   = 3'h1;
    localparam logic [2:0] TMODE_GE_LO   = 3'h2;
    localparam logic [2:0] TMODE_INSIDE  = 3'h3;
    localparam logic [2:0] TMODE_OUTSIDE = 3'h4;
    localparam logic [2:0] TMODE_LE_HI   = 3'h5;
    localparam logic [2:0] TMODE_GT_HI   = 3'h6;
    localparam logic [2:0] TMODE_ALWAYS  = 3'h7;

    typedef enum logic [1:0] {AET_IDLE, AET_WAIT, AET_EVAL} aet_state_e;
endpackage
